// file: logic/peq_defines.svh
`ifndef PEQ_DEFINES_SVH
`define PEQ_DEFINES_SVH

// clock and timebase
`define PEQ_CLK_HZ        25000000
`define PEQ_TB_PERIOD_NS  1000
`define PEQ_TB_CYC        ((`PEQ_TB_PERIOD_NS * (`PEQ_CLK_HZ / 1000000)) / 1000)

// register byte offsets, and the high address nibbles of the capture and average blocks
`define PEQ_A_CTRL        8'h00
`define PEQ_A_SWMODE      8'h04
`define PEQ_A_DBLEN       8'h08
`define PEQ_A_TCFG        8'h0C
`define PEQ_A_TMO         8'h10
`define PEQ_A_TRES        8'h14
`define PEQ_A_TSTAT       8'h18
`define PEQ_A_QCFG        8'h1C
`define PEQ_A_QNET        8'h20
`define PEQ_A_QFWD        8'h24
`define PEQ_A_QREV        8'h28
`define PEQ_A_QDIR        8'h2C
`define PEQ_A_SCANLEN     8'h30
`define PEQ_A_OVF         8'h34
`define PEQ_A_CAP_HI      4'h4
`define PEQ_A_AVG_HI      4'h5

// fields
`define PEQ_CTRL_SCAN     0
`define PEQ_TC_ARM        8
`define PEQ_TC_FALL       6
`define PEQ_QC_CLR        10

// timer modes
`define PEQ_TM_SINGLE     2'h0
`define PEQ_TM_PERIOD     2'h1
`define PEQ_TM_PREV       2'h2
`define PEQ_TM_SCAN       2'h3

// quadrature modes
`define PEQ_QM_X1         2'h0
`define PEQ_QM_X2         2'h1
`define PEQ_QM_X4         2'h2

// reset values and markers
`define PEQ_DBLEN_RST     16'h0005
`define PEQ_TMO_RST       32'h000F4240
`define PEQ_INVALID       32'h7FC00000

`endif

// file: logic/peq_pkg.sv
package peq_pkg;
    typedef logic [31:0] peq_word_t;
    typedef logic [1:0]  peq_mode_t;
    typedef enum logic [1:0] {PEQ_T_IDLE, PEQ_T_WAIT, PEQ_T_MEAS} peq_tstate_e;
endpackage

// file: logic/peq_quad_if.sv
`timescale 1ns/100ps
interface peq_quad_if;
    import peq_pkg::*;
    logic      a;
    logic      b;
    peq_mode_t mode;
    logic      clr;
    peq_word_t net;
    peq_word_t fwd;
    peq_word_t rev;
    logic      dir;
    modport ctl (output a, b, mode, clr, input net, fwd, rev, dir);
    modport dec (input a, b, mode, clr, output net, fwd, rev, dir);
endinterface

// file: logic/peq_quad.sv
`timescale 1ns/100ps
`include "peq_defines.svh"
module peq_quad
    import peq_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // decoder side of the pair
    peq_quad_if.dec  q
);
    logic      a_d_r;
    logic      b_d_r;
    peq_word_t net_r;
    peq_word_t fwd_r;
    peq_word_t rev_r;
    logic      dir_r;

    // transition decode
    wire a_chg  = q.a ^ a_d_r;
    wire b_chg  = q.b ^ b_d_r;
    wire single = a_chg ^ b_chg;
    wire up     = q.a ^ b_d_r;
    wire step_x1 = single & a_chg & (q.a == up);
    wire step_x2 = single & a_chg;
    wire step   = (q.mode == `PEQ_QM_X1) ? step_x1 :
                  (q.mode == `PEQ_QM_X2) ? step_x2 : single;
    wire [31:0] net_base = q.clr ? 32'h00000000 : net_r;
    wire [31:0] fwd_base = q.clr ? 32'h00000000 : fwd_r;
    wire [31:0] rev_base = q.clr ? 32'h00000000 : rev_r;

    // counters, a step in the clear cycle lands in the fresh count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            a_d_r <= 1'b1; // idle lines sit high, no false step after reset
            b_d_r <= 1'b1;
            net_r <= '0;
            fwd_r <= '0;
            rev_r <= '0;
            dir_r <= 1'b0;
        end else begin
            a_d_r <= q.a;
            b_d_r <= q.b;
            net_r <= step ? (up ? net_base + 32'h00000001 : net_base - 32'h00000001)
                          : net_base;
            fwd_r <= (step && up) ? fwd_base + 32'h00000001 : fwd_base;
            rev_r <= (step && !up) ? rev_base + 32'h00000001 : rev_base;
            if (step) begin
                dir_r <= up;
            end
        end
    end

    // results back to the register file
    assign q.net = net_r;
    assign q.fwd = fwd_r;
    assign q.rev = rev_r;
    assign q.dir = dir_r;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_quad_illegal: assert property (a_chg && b_chg && !q.clr |=> $stable(net_r))
        else $error("illegal quadrature transition changed the count");
    a_quad_up_x4: assert property (q.mode == `PEQ_QM_X4 && single && up && !q.clr
                                   |=> net_r == $past(net_r) + 32'h00000001)
        else $error("4x forward step not counted");
    a_quad_x1_rev: assert property (q.mode == `PEQ_QM_X1 && a_chg && !b_chg && !q.a
                                    && !up && !q.clr |=> rev_r == $past(rev_r) + 32'h00000001)
        else $error("1x A falling edge not counted backwards");
endmodule

// file: logic/peq_top.sv
`timescale 1ns/100ps
`include "peq_defines.svh"
module peq_top
    import peq_pkg::*;
#(
    parameter int NCH   = 4,
    parameter int NTERM = 12
)(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // scan scheduler
    input  wire logic        scan_start_i,
    // terminals
    input  wire logic [11:0] term_i
);
    logic              rst_s1_r;
    logic              rst_n_r;
    logic [11:0]       pin_s1_r;
    logic [11:0]       pin_s2_r;
    logic [11:0]       lvl_r;
    logic [11:0]       lvl_d_r;
    logic [15:0]       db_cnt_r [NTERM];
    logic [4:0]        tb_cnt_r;
    logic              tb_tick_r;
    logic [11:0]       swmode_r;
    logic [15:0]       db_len_r;
    logic [7:0]        tcfg_r;
    peq_word_t         tmo_r;
    logic [9:0]        qcfg_r;
    peq_word_t         acc_r [NCH];
    peq_word_t         cap_r [NCH];
    peq_word_t         avg_r [NCH];
    logic [NCH-1:0]    ovf_r;
    logic [NCH-1:0]    ovf_cap_r;
    peq_word_t         scan_us_r;
    peq_word_t         scan_len_r;
    peq_tstate_e       t_state_r;
    peq_word_t         t_cnt_r;
    peq_word_t         w_cnt_r;
    peq_word_t         t_res_r;
    logic              t_done_r;
    peq_word_t         rdata;

    // byte-lane merge for register writes
    function automatic peq_word_t bmerge(input peq_word_t old, input peq_word_t nw,
                                         input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                old[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return old;
    endfunction

    // terminal select, out-of-range picks read low
    function automatic logic pick(input logic [11:0] v, input logic [3:0] k);
        return (k < 4'hC) ? v[k] : 1'b0;
    endfunction

    // reset release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // pin synchroniser and 1 us timebase
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_s1_r  <= '1; // idle terminals sit high on their pull-ups
            pin_s2_r  <= '1;
            tb_cnt_r  <= '0;
            tb_tick_r <= 1'b0;
        end else begin
            pin_s1_r  <= term_i;
            pin_s2_r  <= pin_s1_r;
            tb_tick_r <= (tb_cnt_r == 5'(`PEQ_TB_CYC - 1));
            tb_cnt_r  <= (tb_cnt_r == 5'(`PEQ_TB_CYC - 1)) ? 5'h00 : tb_cnt_r + 5'h01;
        end
    end

    // bus decode
    wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr     = req & wb_we_i;
    wire wr_ctl = wr && wb_adr_i == `PEQ_A_CTRL;
    wire wr_sw  = wr && wb_adr_i == `PEQ_A_SWMODE;
    wire wr_db  = wr && wb_adr_i == `PEQ_A_DBLEN;
    wire wr_tc  = wr && wb_adr_i == `PEQ_A_TCFG;
    wire wr_tmo = wr && wb_adr_i == `PEQ_A_TMO;
    wire wr_qc  = wr && wb_adr_i == `PEQ_A_QCFG;
    wire [31:0] wmix = bmerge(32'h00000000, wb_dat_i, wb_sel_i);
    wire [31:0] sw_new = bmerge({20'h00000, swmode_r}, wb_dat_i, wb_sel_i);
    wire [31:0] db_new = bmerge({16'h0000, db_len_r}, wb_dat_i, wb_sel_i);
    wire [31:0] tc_new = bmerge({24'h000000, tcfg_r}, wb_dat_i, wb_sel_i);
    wire [31:0] qc_new = bmerge({22'h000000, qcfg_r}, wb_dat_i, wb_sel_i);

    // edges of the filtered levels
    wire [11:0] rise = lvl_r & ~lvl_d_r;
    wire [11:0] fall = ~lvl_r & lvl_d_r;
    wire [11:0] cnt_ev = (swmode_r & fall) | (~swmode_r & rise); // closures pull low
    wire        scan_go = scan_start_i | (wr_ctl & wmix[`PEQ_CTRL_SCAN]);

    // software-written configuration
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            swmode_r <= '0;
            db_len_r <= `PEQ_DBLEN_RST;
            tcfg_r   <= '0;
            tmo_r    <= `PEQ_TMO_RST;
            qcfg_r   <= '0;
        end else begin
            if (wr_sw)  swmode_r <= sw_new[11:0];
            if (wr_db)  db_len_r <= db_new[15:0];
            if (wr_tc)  tcfg_r   <= tc_new[7:0];
            if (wr_tmo) tmo_r    <= bmerge(tmo_r, wb_dat_i, wb_sel_i);
            if (wr_qc)  qcfg_r   <= qc_new[9:0];
        end
    end

    // debounce: a new level must hold db_len microseconds
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            lvl_r   <= '1; // matches the idle pin, so no edge follows reset
            lvl_d_r <= '1;
            for (int i = 0; i < NTERM; i++) begin
                db_cnt_r[i] <= '0;
            end
        end else begin
            lvl_d_r <= lvl_r;
            for (int i = 0; i < NTERM; i++) begin
                if (!swmode_r[i] || pin_s2_r[i] == lvl_r[i]) begin
                    db_cnt_r[i] <= '0;
                end else if (tb_tick_r) begin
                    db_cnt_r[i] <= db_cnt_r[i] + 16'h0001;
                end
                if (!swmode_r[i]) begin
                    lvl_r[i] <= pin_s2_r[i];
                end else if (pin_s2_r[i] != lvl_r[i] && db_cnt_r[i] >= db_len_r) begin
                    lvl_r[i] <= pin_s2_r[i];
                end
            end
        end
    end

    // accumulators run at all times; scan captures and clears them
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ovf_r      <= '0;
            ovf_cap_r  <= '0;
            scan_us_r  <= '0;
            scan_len_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                acc_r[i] <= '0;
                cap_r[i] <= '0;
                avg_r[i] <= '0;
            end
        end else begin
            if (scan_go) begin
                scan_us_r  <= '0;
                scan_len_r <= scan_us_r;
            end else if (tb_tick_r) begin
                scan_us_r <= scan_us_r + 32'h00000001;
            end
            for (int i = 0; i < NCH; i++) begin
                if (scan_go) begin
                    cap_r[i]     <= acc_r[i];
                    avg_r[i]     <= avg_r[i] - (avg_r[i] >> 2) + (acc_r[i] >> 2);
                    ovf_cap_r[i] <= ovf_r[i];
                    ovf_r[i]     <= 1'b0;
                    acc_r[i]     <= cnt_ev[i] ? 32'h00000001 : 32'h00000000;
                end else if (cnt_ev[i]) begin
                    acc_r[i] <= acc_r[i] + 32'h00000001;
                    if (acc_r[i] == 32'hFFFFFFFF) begin
                        ovf_r[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // edge timer selection
    wire [3:0]  t_sel   = tcfg_r[3:0];
    wire [1:0]  t_mode  = tcfg_r[5:4];
    wire [11:0] t_edges = tcfg_r[`PEQ_TC_FALL] ? fall : rise;
    wire        ev_sel  = pick(t_edges, t_sel);
    wire        ev_prev = pick(t_edges, (t_sel == 4'h0) ? 4'hB : t_sel - 4'h1);
    wire        t_arm   = wr_tc & wmix[`PEQ_TC_ARM];
    wire [1:0]  t_amode = tc_new[5:4]; // mode being written, tcfg_r still old
    wire        t_start = (t_mode == `PEQ_TM_PERIOD) ? ev_sel : ev_prev;
    wire [31:0] t_meas  = (t_mode == `PEQ_TM_SCAN) ? scan_us_r : t_cnt_r;
    wire        t_tmo   = w_cnt_r >= tmo_r;

    // edge timer
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            t_state_r <= PEQ_T_IDLE;
            t_cnt_r   <= '0;
            w_cnt_r   <= '0;
            t_res_r   <= '0;
            t_done_r  <= 1'b0;
        end else begin
            if (tb_tick_r) begin
                t_cnt_r <= t_cnt_r + 32'h00000001;
                w_cnt_r <= w_cnt_r + 32'h00000001;
            end
            unique case (t_state_r)
                PEQ_T_IDLE: begin
                    if (t_arm) begin
                        t_cnt_r   <= '0;
                        w_cnt_r   <= '0;
                        t_done_r  <= 1'b0;
                        t_state_r <= (t_amode == `PEQ_TM_SINGLE || t_amode == `PEQ_TM_SCAN)
                                     ? PEQ_T_MEAS : PEQ_T_WAIT;
                    end
                end
                PEQ_T_WAIT: begin
                    if (t_start) begin
                        t_cnt_r   <= '0;
                        t_state_r <= PEQ_T_MEAS;
                    end else if (t_tmo) begin
                        t_res_r   <= `PEQ_INVALID;
                        t_done_r  <= 1'b1;
                        t_state_r <= PEQ_T_IDLE;
                    end
                end
                PEQ_T_MEAS: begin
                    if (ev_sel) begin
                        t_res_r   <= (t_meas == 32'h00000000) ? `PEQ_INVALID : t_meas;
                        t_done_r  <= 1'b1;
                        t_state_r <= PEQ_T_IDLE;
                    end else if (t_tmo) begin
                        t_res_r   <= `PEQ_INVALID;
                        t_done_r  <= 1'b1;
                        t_state_r <= PEQ_T_IDLE;
                    end
                end
            endcase
        end
    end

    // quadrature pair from any two terminals
    peq_quad_if qi ();
    assign qi.a    = pick(lvl_r, qcfg_r[3:0]);
    assign qi.b    = pick(lvl_r, qcfg_r[7:4]);
    assign qi.mode = qcfg_r[9:8];
    assign qi.clr  = wr_qc & wmix[`PEQ_QC_CLR];

    peq_quad u_quad (
        .clk_sys (clk_sys),
        .rst_n   (rst_n_r),
        .q       (qi)
    );

    // read mux, unmapped words read zero
    wire [1:0] ix  = wb_adr_i[3:2];
    wire       ixv = 32'(ix) < NCH;
    assign rdata =
        (wb_adr_i == `PEQ_A_SWMODE)  ? {20'h00000, swmode_r} :
        (wb_adr_i == `PEQ_A_DBLEN)   ? {16'h0000, db_len_r} :
        (wb_adr_i == `PEQ_A_TCFG)    ? {24'h000000, tcfg_r} :
        (wb_adr_i == `PEQ_A_TMO)     ? tmo_r :
        (wb_adr_i == `PEQ_A_TRES)    ? t_res_r :
        (wb_adr_i == `PEQ_A_TSTAT)   ? {30'h00000000, t_done_r, t_state_r != PEQ_T_IDLE} :
        (wb_adr_i == `PEQ_A_QCFG)    ? {22'h000000, qcfg_r} :
        (wb_adr_i == `PEQ_A_QNET)    ? qi.net :
        (wb_adr_i == `PEQ_A_QFWD)    ? qi.fwd :
        (wb_adr_i == `PEQ_A_QREV)    ? qi.rev :
        (wb_adr_i == `PEQ_A_QDIR)    ? {31'h00000000, qi.dir} :
        (wb_adr_i == `PEQ_A_SCANLEN) ? scan_len_r :
        (wb_adr_i == `PEQ_A_OVF)     ? 32'(ovf_cap_r) :
        (wb_adr_i[7:4] == `PEQ_A_CAP_HI && ixv && !wb_adr_i[1]) ? cap_r[ix] :
        (wb_adr_i[7:4] == `PEQ_A_AVG_HI && ixv && !wb_adr_i[1]) ? avg_r[ix] :
        32'h00000000;

    // single-cycle acknowledge with registered read data
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rdata;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n_r);
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_bus_ack_pulse: assert property (req |=> s_ack_pulse)
        else $error("bus ack is not a one-cycle answer");
    a_scan_capture: assert property (scan_go && !cnt_ev[0]
                                     |=> acc_r[0] == 32'h00000000 && cap_r[0] == $past(acc_r[0]))
        else $error("scan did not capture and clear accumulator 0");
    a_acc_count: assert property (!scan_go && cnt_ev[0]
                                  |=> acc_r[0] == $past(acc_r[0]) + 32'h00000001)
        else $error("edge not counted on channel 0");
    a_ovf_sticky: assert property (!scan_go && cnt_ev[0] && acc_r[0] == 32'hFFFFFFFF
                                   |=> ovf_r[0] ##1 (ovf_r[0] || $past(scan_go)))
        else $error("overflow flag did not set and hold");
    a_db_hold: assert property (swmode_r[0] && pin_s2_r[0] != lvl_r[0]
                                && db_cnt_r[0] < db_len_r |=> $stable(lvl_r[0]))
        else $error("debounced level moved before the stable time");
    a_tmr_timeout: assert property (((t_state_r == PEQ_T_WAIT && !t_start) ||
                                     (t_state_r == PEQ_T_MEAS && !ev_sel)) && t_tmo
                                    |=> t_done_r && t_res_r == `PEQ_INVALID)
        else $error("timer timeout did not give the invalid marker");
    a_tb_period: assert property (tb_tick_r |=> !tb_tick_r [*8])
        else $error("timebase ticks too close together");
endmodule

// file: verif/peq_sensor_model.sv
`timescale 1ns/100ps
// stands in for pulse sensors, switch contacts and a shaft encoder
module peq_sensor_model (
    // clock
    input  wire logic        clk_sys,
    // terminal levels
    output logic      [11:0] term
);
    // encoder phase order (a,b) when channel a leads
    localparam logic [1:0] QSEQ [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    int qph;

    // idle lines sit high, as with a pull-up and the contact open
    initial begin
        term = 12'hFFF;
        qph  = 2;
    end

    // n low-then-high pulses of w cycles per level, one rising edge each
    task automatic pulse(input int ch, input int n, input int w);
        repeat (n) begin
            term[ch] <= 1'b0;
            repeat (w) @(posedge clk_sys);
            term[ch] <= 1'b1;
            repeat (w) @(posedge clk_sys);
        end
    endtask

    // one closure and one release, each chattering before it settles
    task automatic closure(input int ch, input int hold);
        for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 7; k++) begin
                term[ch] <= k[0] ^ e[0];
                repeat (3) @(posedge clk_sys);
            end
            repeat (hold) @(posedge clk_sys);
        end
    endtask

    // span 1 steps forward, 3 steps back, 2 moves both lines at once
    task automatic quad(input int a, input int b, input int span, input int n);
        repeat (n) begin
            qph = (qph + span) % 4;
            term[a] <= QSEQ[qph][1];
            term[b] <= QSEQ[qph][0];
            repeat (8) @(posedge clk_sys);
        end
    endtask
endmodule

// file: verif/pulse_edge_quadrature_counter_tb.sv
`timescale 1ns/100ps
`include "peq_defines.svh"
// compare one value with its expectation and keep the tally
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end

module pulse_edge_quadrature_counter_tb
    import peq_pkg::*;
;
    logic        clk_sys;
    logic        arst_n;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    peq_word_t   wb_dat;
    peq_word_t   wb_dat_o;
    logic        wb_ack_o;
    logic        scan_start;
    logic [11:0] term;
    peq_word_t   rd;
    int          num_errors;
    int          samples_checked;
    int          qexp [3] = '{1, 2, 4};

    // terminals 0-1 count, 2-3 time, 4-9 decode: each keeps one function
    peq_top #(.NCH(4), .NTERM(12)) dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_start_i(scan_start),
        .term_i(term));
    peq_sensor_model sensor_u (.clk_sys(clk_sys), .term(term));

    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // one classic cycle; ack is due at the second edge, the watchdog ends a hang
    task automatic wb(input logic we, input logic [7:0] adr, input peq_word_t wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= wd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1);
        `CHK(n, 2)
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    // one-cycle scan start after the inputs have settled
    task automatic scan();
        repeat (8) @(posedge clk_sys);
        scan_start <= 1'b1;
        @(posedge clk_sys);
        scan_start <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic timer_arm(input logic [1:0] mode, input logic [3:0] sel);
        wb(1'b1, `PEQ_A_TCFG, {23'h0, 1'b1, 2'h0, mode, sel});
    endtask

    // poll until done, then fetch the result into rd
    task automatic timer_wait();
        int n;
        n = 0;
        rd = '0;
        while (rd[1] !== 1'b1 && n < 400) begin
            wb(1'b0, `PEQ_A_TSTAT, 32'h0);
            n++;
        end
        wb(1'b0, `PEQ_A_TRES, 32'h0);
    endtask

    task automatic t_regs();
        wb(1'b0, `PEQ_A_DBLEN, 32'h0);
        `CHK(rd, {16'h0, `PEQ_DBLEN_RST})
        wb(1'b0, `PEQ_A_TMO, 32'h0);
        `CHK(rd, `PEQ_TMO_RST)
        wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h3C, 32'h0);
        `CHK(rd, 32'h0)
    endtask

    // edges between scans land in the next capture, then it restarts at 0
    task automatic t_count();
        scan();
        sensor_u.pulse(0, 5, 3);
        sensor_u.pulse(1, 3, 3);
        scan();
        wb(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h5)
        wb(1'b0, 8'h44, 32'h0);
        `CHK(rd, 32'h3)
        scan();
        wb(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h0)
        wb(1'b0, 8'h50, 32'h0);
        `CHK(rd, 32'h1)
        wb(1'b0, `PEQ_A_OVF, 32'h0);
        `CHK(rd, 32'h0)
        repeat (250) @(posedge clk_sys);
        wb(1'b1, `PEQ_A_CTRL, 32'h1);
        wb(1'b0, `PEQ_A_SCANLEN, 32'h0);
        `CHK(rd >= 10 && rd <= 11, 1'b1)
    endtask

    // short pulses and chatter on the contact input count nothing extra
    task automatic t_switch();
        wb(1'b1, `PEQ_A_SWMODE, 32'h1);
        wb(1'b1, `PEQ_A_DBLEN, 32'h2);
        scan();
        sensor_u.pulse(0, 3, 4);
        sensor_u.pulse(1, 3, 4);
        sensor_u.closure(0, 150);
        scan();
        wb(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h1)
        wb(1'b0, 8'h44, 32'h0);
        `CHK(rd, 32'h3)
    endtask

    task automatic t_timer();
        wb(1'b1, `PEQ_A_TMO, 32'd20);
        timer_arm(2'h0, 4'd2);
        timer_wait();
        `CHK(rd, `PEQ_INVALID)
        timer_arm(2'h0, 4'd2);
        repeat (250) @(posedge clk_sys);
        sensor_u.pulse(2, 1, 4);
        timer_wait();
        `CHK(rd >= 9 && rd <= 11, 1'b1)
        timer_arm(2'h1, 4'd2);
        sensor_u.pulse(2, 2, 1);
        timer_wait();
        `CHK(rd, `PEQ_INVALID)
        timer_arm(2'h2, 4'd3);
        sensor_u.pulse(2, 1, 4);
        repeat (121) @(posedge clk_sys);
        sensor_u.pulse(3, 1, 4);
        timer_wait();
        `CHK(rd >= 4 && rd <= 6, 1'b1)
        scan();
        wb(1'b1, `PEQ_A_TCFG, {23'h0, 1'b1, 1'b0, 1'b1, 2'h3, 4'd2});
        repeat (200) @(posedge clk_sys);
        sensor_u.pulse(2, 1, 4);
        timer_wait();
        `CHK(rd >= 7 && rd <= 10, 1'b1)
    endtask

    // one full forward cycle per mode on a fresh pair, then back again
    task automatic t_quad();
        for (int m = 0; m < 3; m++) begin
            wb(1'b1, `PEQ_A_QCFG, {21'h0, 1'b1, 2'(m), 4'(5 + 2 * m), 4'(4 + 2 * m)});
            sensor_u.quad(4 + 2 * m, 5 + 2 * m, 1, 4);
            wb(1'b0, `PEQ_A_QNET, 32'h0);
            `CHK(rd, 32'(qexp[m]))
            sensor_u.quad(4 + 2 * m, 5 + 2 * m, 3, 4);
            wb(1'b0, `PEQ_A_QNET, 32'h0);
            `CHK(rd, 32'h0)
        end
        wb(1'b0, `PEQ_A_QFWD, 32'h0);
        `CHK(rd, 32'h4)
        wb(1'b0, `PEQ_A_QREV, 32'h0);
        `CHK(rd, 32'h4)
        wb(1'b0, `PEQ_A_QDIR, 32'h0);
        `CHK(rd[0], 1'b0)
        sensor_u.quad(8, 9, 2, 1);
        wb(1'b0, `PEQ_A_QNET, 32'h0);
        `CHK(rd, 32'h0)
        sensor_u.quad(8, 9, 3, 1);
        wb(1'b0, `PEQ_A_QNET, 32'h0);
        `CHK(rd, 32'hFFFF_FFFF)
    endtask

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        arst_n          = 1'b0;
        wb_cyc          = 1'b0;
        wb_stb          = 1'b0;
        wb_we           = 1'b0;
        wb_adr          = 8'h00;
        wb_dat          = 32'h0;
        scan_start      = 1'b0;
        num_errors      = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_count();
        t_switch();
        t_timer();
        t_quad();
        finish_test();
    end

    // the whole run needs well under this many cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end
endmodule
